// ### rlc_cfg.svh
`ifndef RLC_CFG_SVH
`define RLC_CFG_SVH

// ****************************************************************
// Register addresses
// ****************************************************************
`define RLC_ADDR_IDLE     8'h39
`define RLC_ADDR_EQ       8'h3A
`define RLC_ADDR_SWING    8'h3B
`define RLC_ADDR_DEEMPH   8'h3C
`define RLC_ADDR_THRESH   8'h3D
`define RLC_ADDR_RSVD     8'h3E
`define RLC_ADDR_FORCE    8'h3F
`define RLC_NUM_REGS      7

// ****************************************************************
// Reset values
// ****************************************************************
`define RLC_RST_IDLE      8'h00
`define RLC_RST_EQ        8'h2F
`define RLC_RST_SWING     8'hAD
`define RLC_RST_DEEMPH    8'h02
`define RLC_RST_THRESH    8'h00
`define RLC_RST_RSVD      8'h00
`define RLC_RST_FORCE     8'h00

// ****************************************************************
// Write masks for the bus and for the EEPROM load
// ****************************************************************
`define RLC_BUS_MASK_DEEMPH 8'h1F
`define RLC_EE_MASK_IDLE    8'h3C
`define RLC_EE_MASK_EQ      8'hFF
`define RLC_EE_MASK_SWING   8'hFF
`define RLC_EE_MASK_DEEMPH  8'h07
`define RLC_EE_MASK_THRESH  8'h0F
`define RLC_EE_MASK_NONE    8'h00

// ****************************************************************
// Field positions
// ****************************************************************
`define RLC_IDLE_MANUAL   5
`define RLC_IDLE_SEL      4
`define RLC_FAR_RECEIVER_DETECT_MODE_HI      3
`define RLC_FAR_RECEIVER_DETECT_MODE_LO      2
`define RLC_SWING_SCP     7
`define RLC_SWING_GEN     6
`define RLC_FORCE_OFF     2
`define RLC_FORCE_ON      1

// ****************************************************************
// Receiver-detect codes and timing
// ****************************************************************
`define RLC_FAR_RECEIVER_DETECT_MODE_HIZ     2'h0
`define RLC_FAR_RECEIVER_DETECT_MODE_ONCE    2'h1
`define RLC_FAR_RECEIVER_DETECT_MODE_REPEAT  2'h2
`define RLC_FAR_RECEIVER_DETECT_MODE_FIFTY   2'h3
`define RLC_CLK_PERIOD_NS 100
`define RLC_TEST_EVERY_NS 12000000
`define RLC_TEST_CYC      (`RLC_TEST_EVERY_NS / `RLC_CLK_PERIOD_NS)
`define RLC_TEST_LIMIT    6'h32
`define RLC_PROBE_CYC     4
`define RLC_CNT_W         24

`endif

// ### rlc_pkg.sv
package rlc_pkg;

	typedef enum logic {
		RLC_TERM_HIZ   = 1'b0,
		RLC_TERM_FIFTY = 1'b1
	} rlc_term_type;

	typedef enum logic [2:0] {
		RLC_DET_OFF   = 3'h0,
		RLC_DET_WAIT  = 3'h1,
		RLC_DET_PROBE = 3'h3,
		RLC_DET_FOUND = 3'h2,
		RLC_DET_GIVEUP = 3'h6
	} rlc_det_state_type;

	typedef struct packed {
		logic [7:0] equalizerLevel;
		logic       scpEnable;
		logic       earlyGenSelect;
		logic [2:0] outputSwing;
		logic [2:0] deemphasisLevel;
		logic [1:0] assertThreshold;
		logic [1:0] deassertThreshold;
	} rlc_lane_cfg_type;

endpackage : rlc_pkg

// ### rlc_sync2.sv
module rlc_sync2 #(
	parameter int WIDTH = 1
) (
	input  wire logic             mclk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] asyncIn,
	output logic      [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_r;

	always_ff @(posedge mclk) begin
		if (rst) begin
			stage1_r <= '0;
			syncOut  <= '0;
		end else begin
			stage1_r <= asyncIn;
			syncOut  <= stage1_r;
		end
	end

endmodule : rlc_sync2

// ### rlc_far_receiver_detect_mode_seq.sv
`include "rlc_cfg.svh"

module rlc_far_receiver_detect_mode_seq #(
	parameter int TEST_CYC = `RLC_TEST_CYC
) (
	input  wire logic       mclk,
	input  wire logic       rst,
	input  wire logic [1:0] detMode,
	input  wire logic       rxSeen,
	output logic            probe_r,
	output logic            found_r
);

	rlc_pkg::rlc_det_state_type state_r;
	rlc_pkg::rlc_det_state_type state_nxt;
	logic [1:0]            modeLast_r;
	logic [`RLC_CNT_W-1:0] cnt_r;
	logic [`RLC_CNT_W-1:0] cnt_nxt;
	logic [5:0]            tries_r;
	logic [5:0]            tries_nxt;
	wire logic modeAuto = (detMode == `RLC_FAR_RECEIVER_DETECT_MODE_ONCE)
		|| (detMode == `RLC_FAR_RECEIVER_DETECT_MODE_REPEAT);
	wire logic restart = !modeAuto || (detMode != modeLast_r);
	wire logic [`RLC_CNT_W-1:0] gapLoad =
		`RLC_CNT_W'(TEST_CYC - `RLC_PROBE_CYC - 1);

	// ****************************************************************
	// Test scheduling
	// ****************************************************************
	always_comb begin
		state_nxt = state_r;
		cnt_nxt   = cnt_r;
		tries_nxt = tries_r;
		case (state_r)
			rlc_pkg::RLC_DET_OFF: begin
				tries_nxt = 6'h0;
				cnt_nxt   = gapLoad;
				state_nxt = rlc_pkg::RLC_DET_WAIT;
			end
			rlc_pkg::RLC_DET_WAIT: begin
				if (cnt_r == '0) begin
					state_nxt = rlc_pkg::RLC_DET_PROBE;
					cnt_nxt   = `RLC_CNT_W'(`RLC_PROBE_CYC - 1);
					// Saturate so the endless mode cannot wrap the count.
					tries_nxt = (tries_r == `RLC_TEST_LIMIT) ? tries_r
						: tries_r + 6'h1;
				end else begin
					cnt_nxt = cnt_r - `RLC_CNT_W'(1);
				end
			end
			rlc_pkg::RLC_DET_PROBE: begin
				if (rxSeen) begin
					state_nxt = rlc_pkg::RLC_DET_FOUND;
				end else if (cnt_r != '0) begin
					cnt_nxt = cnt_r - `RLC_CNT_W'(1);
				end else if (detMode == `RLC_FAR_RECEIVER_DETECT_MODE_ONCE
						&& tries_r == `RLC_TEST_LIMIT) begin
					state_nxt = rlc_pkg::RLC_DET_GIVEUP;
				end else begin
					state_nxt = rlc_pkg::RLC_DET_WAIT;
					cnt_nxt   = gapLoad;
				end
			end
			default: begin
			end
		endcase
		if (restart) begin
			state_nxt = rlc_pkg::RLC_DET_OFF;
		end
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			state_r    <= rlc_pkg::RLC_DET_OFF;
			modeLast_r <= 2'h0;
			cnt_r      <= '0;
			tries_r    <= 6'h0;
			probe_r    <= 1'b0;
			found_r    <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			modeLast_r <= detMode;
			cnt_r      <= cnt_nxt;
			tries_r    <= tries_nxt;
			probe_r    <= state_nxt == rlc_pkg::RLC_DET_PROBE;
			found_r    <= state_nxt == rlc_pkg::RLC_DET_FOUND;
		end
	end

	try_limit_a:
	assert property (@(posedge mclk) disable iff (rst)
		tries_r <= `RLC_TEST_LIMIT)
		else $error("more receiver tests than allowed");

	endless_repeat_a:
	assert property (@(posedge mclk) disable iff (rst)
		(detMode == `RLC_FAR_RECEIVER_DETECT_MODE_REPEAT && $stable(detMode))
		|-> state_r != rlc_pkg::RLC_DET_GIVEUP)
		else $error("repeat mode stopped testing");

	probe_length_a:
	assert property (@(posedge mclk) disable iff (rst)
		($rose(probe_r) && !rxSeen && !restart) |=> probe_r)
		else $error("probe window too short");

endmodule : rlc_far_receiver_detect_mode_seq

// ### rlc_lane_regs.sv
// Behaviour
// - Manual-idle bit selects manual or automatic muting.
// - Manual idle mutes output when select is one.
// - Detect code 00 high impedance, 11 fifty ohm.
// - Code 01 tests every 12 ms, fifty times.
// - Code 10 tests every 12 ms until found.
// - Auto modes hold high impedance until detection.
// - Equalizer byte read/write, reset value 2F.
// - Swing bit 7 enables short-circuit protection.
// - Rate override bit selects early generations.
// - Swing field selects 0.7 V to 1.4 V.
// - De-emphasis bit 7 reports receiver found.
// - Bits 6:5 report rate when pin automatic.
// - De-emphasis field selects 0 to -12 dB.
// - Threshold fields select assert and deassert levels.
// - Force-off bit forces signal detect off.
// - Force-on bit forces signal detect on unless force-off is also set.
`include "rlc_cfg.svh"

module rlc_lane_regs #(
	parameter int TEST_CYC = `RLC_TEST_CYC
) (
	input  wire logic                      mclk,
	input  wire logic                      rst,
	input  wire logic [7:0]                regAddr,
	input  wire logic [7:0]                regWrData,
	input  wire logic                      regWrEn,
	input  wire logic                      regRdEn,
	output logic      [7:0]                regRdData_r,
	input  wire logic [7:0]                eeAddr,
	input  wire logic [7:0]                eeData,
	input  wire logic                      eeLoadEn,
	input  wire logic                      autoIdlePin,
	input  wire logic                      farReceiverPin,
	input  wire logic                      rateAutoPin,
	input  wire logic [1:0]                detectedRatePin,
	input  wire logic                      nextSignalPin,
	output logic                           outputMute_r,
	output rlc_pkg::rlc_term_type          termination_r,
	output logic                           receiverProbe_r,
	output rlc_pkg::rlc_lane_cfg_type      laneCfg_r,
	output logic                           nextSignalDetect_r
);

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic       autoIdleS;
	logic       farReceiverS;
	logic       rateAutoS;
	logic [1:0] detectedRateS;
	logic       nextSignalS;

	rlc_sync2 #(.WIDTH(5)) pinSync (
		.mclk    (mclk),
		.rst     (rst),
		.asyncIn ({autoIdlePin, farReceiverPin, rateAutoPin,
			detectedRatePin}),
		.syncOut ({autoIdleS, farReceiverS, rateAutoS, detectedRateS})
	);

	rlc_sync2 #(.WIDTH(1)) nextSync (
		.mclk    (mclk),
		.rst     (rst),
		.asyncIn (nextSignalPin),
		.syncOut (nextSignalS)
	);

	// ****************************************************************
	// Register storage
	// ****************************************************************
	logic [7:0] idleReg_r;
	logic [7:0] eqReg_r;
	logic [7:0] swingReg_r;
	logic [7:0] deemphReg_r;
	logic [7:0] threshReg_r;
	logic [7:0] rsvdReg_r;
	logic [7:0] forceReg_r;
	logic       found;

	wire logic wrIdle   = regWrEn && regAddr == `RLC_ADDR_IDLE;
	wire logic wrEq     = regWrEn && regAddr == `RLC_ADDR_EQ;
	wire logic wrSwing  = regWrEn && regAddr == `RLC_ADDR_SWING;
	wire logic wrDeemph = regWrEn && regAddr == `RLC_ADDR_DEEMPH;
	wire logic wrThresh = regWrEn && regAddr == `RLC_ADDR_THRESH;
	wire logic wrRsvd   = regWrEn && regAddr == `RLC_ADDR_RSVD;
	wire logic wrForce  = regWrEn && regAddr == `RLC_ADDR_FORCE;

	wire logic eeIdle   = eeLoadEn && eeAddr == `RLC_ADDR_IDLE;
	wire logic eeEq     = eeLoadEn && eeAddr == `RLC_ADDR_EQ;
	wire logic eeSwing  = eeLoadEn && eeAddr == `RLC_ADDR_SWING;
	wire logic eeDeemph = eeLoadEn && eeAddr == `RLC_ADDR_DEEMPH;
	wire logic eeThresh = eeLoadEn && eeAddr == `RLC_ADDR_THRESH;

	// A bus write in the same cycle as a load wins, since it is the
	// later intent of software.
	function automatic logic [7:0] rlc_merge(
		input logic [7:0] cur,
		input logic       eeHit,
		input logic [7:0] eeMask,
		input logic       wrHit,
		input logic [7:0] wrMask
	);
		logic [7:0] v;
		v = cur;
		if (eeHit) begin
			v = (v & ~eeMask) | (eeData & eeMask);
		end
		if (wrHit) begin
			v = (v & ~wrMask) | (regWrData & wrMask);
		end
		return v;
	endfunction : rlc_merge

	wire logic [7:0] idleNxt = rlc_merge(idleReg_r, eeIdle,
		`RLC_EE_MASK_IDLE, wrIdle, 8'hFF);
	wire logic [7:0] eqNxt = rlc_merge(eqReg_r, eeEq,
		`RLC_EE_MASK_EQ, wrEq, 8'hFF);
	wire logic [7:0] swingNxt = rlc_merge(swingReg_r, eeSwing,
		`RLC_EE_MASK_SWING, wrSwing, 8'hFF);
	wire logic [7:0] deemphNxt = rlc_merge(deemphReg_r, eeDeemph,
		`RLC_EE_MASK_DEEMPH, wrDeemph, `RLC_BUS_MASK_DEEMPH);
	wire logic [7:0] threshNxt = rlc_merge(threshReg_r, eeThresh,
		`RLC_EE_MASK_THRESH, wrThresh, 8'hFF);
	wire logic [7:0] rsvdNxt = rlc_merge(rsvdReg_r, 1'b0,
		`RLC_EE_MASK_NONE, wrRsvd, 8'hFF);
	wire logic [7:0] forceNxt = rlc_merge(forceReg_r, 1'b0,
		`RLC_EE_MASK_NONE, wrForce, 8'hFF);

	always_ff @(posedge mclk) begin
		if (rst) begin
			idleReg_r   <= `RLC_RST_IDLE;
			eqReg_r     <= `RLC_RST_EQ;
			swingReg_r  <= `RLC_RST_SWING;
			deemphReg_r <= `RLC_RST_DEEMPH;
			threshReg_r <= `RLC_RST_THRESH;
			rsvdReg_r   <= `RLC_RST_RSVD;
			forceReg_r  <= `RLC_RST_FORCE;
		end else begin
			idleReg_r   <= idleNxt;
			eqReg_r     <= eqNxt;
			swingReg_r  <= swingNxt;
			deemphReg_r <= deemphNxt;
			threshReg_r <= threshNxt;
			rsvdReg_r   <= rsvdNxt;
			forceReg_r  <= forceNxt;
		end
	end

	// ****************************************************************
	// Read path
	// ****************************************************************
	// The detector code is meaningless unless the pin asks for it, so
	// software sees zero rather than a stale guess.
	// rate valid in auto
	wire logic [1:0] rateReport = rateAutoS ? detectedRateS : 2'h0;
	wire logic [7:0] deemphRead = {found, rateReport, deemphReg_r[4:0]};
	logic [7:0] rdMux;

	always_comb begin
		case (regAddr)
			`RLC_ADDR_IDLE:   rdMux = idleReg_r;
			`RLC_ADDR_EQ:     rdMux = eqReg_r;
			`RLC_ADDR_SWING:  rdMux = swingReg_r;
			`RLC_ADDR_DEEMPH: rdMux = deemphRead;
			`RLC_ADDR_THRESH: rdMux = threshReg_r;
			`RLC_ADDR_RSVD:   rdMux = rsvdReg_r;
			`RLC_ADDR_FORCE:  rdMux = forceReg_r;
			default:          rdMux = 8'h00;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			regRdData_r <= 8'h00;
		end else if (regRdEn) begin
			regRdData_r <= rdMux;
		end
	end

	// ****************************************************************
	// Receiver detection and termination
	// ****************************************************************
	wire logic [1:0] detMode =
		idleReg_r[`RLC_FAR_RECEIVER_DETECT_MODE_HI:`RLC_FAR_RECEIVER_DETECT_MODE_LO];
	logic probe;

	rlc_far_receiver_detect_mode_seq #(.TEST_CYC(TEST_CYC)) far_receiver_detect_mode (
		.mclk    (mclk),
		.rst     (rst),
		.detMode (detMode),
		.rxSeen  (farReceiverS),
		.probe_r (probe),
		.found_r (found)
	);

	wire rlc_pkg::rlc_term_type termNxt =
		(detMode == `RLC_FAR_RECEIVER_DETECT_MODE_FIFTY || (detMode != `RLC_FAR_RECEIVER_DETECT_MODE_HIZ
		&& found)) ? rlc_pkg::RLC_TERM_FIFTY : rlc_pkg::RLC_TERM_HIZ;

	// ****************************************************************
	// Lane controls
	// ****************************************************************
	// mute source
	wire logic muteNxt = idleReg_r[`RLC_IDLE_MANUAL]
		? idleReg_r[`RLC_IDLE_SEL] : autoIdleS;
	wire logic sigNxt = forceReg_r[`RLC_FORCE_OFF] ? 1'b0
		: forceReg_r[`RLC_FORCE_ON] ? 1'b1 : nextSignalS;
	rlc_pkg::rlc_lane_cfg_type cfgNxt;

	always_comb begin
		cfgNxt.equalizerLevel    = eqReg_r;
		cfgNxt.scpEnable         = swingReg_r[`RLC_SWING_SCP];
		cfgNxt.earlyGenSelect    = swingReg_r[`RLC_SWING_GEN];
		cfgNxt.outputSwing       = swingReg_r[2:0];
		cfgNxt.deemphasisLevel   = deemphReg_r[2:0];
		cfgNxt.assertThreshold   = threshReg_r[3:2];
		cfgNxt.deassertThreshold = threshReg_r[1:0];
	end

	always_ff @(posedge mclk) begin
		if (rst) begin
			outputMute_r       <= 1'b0;
			termination_r      <= rlc_pkg::RLC_TERM_HIZ;
			receiverProbe_r    <= 1'b0;
			laneCfg_r          <= '0;
			nextSignalDetect_r <= 1'b0;
		end else begin
			outputMute_r       <= muteNxt;
			termination_r      <= termNxt;
			receiverProbe_r    <= probe;
			laneCfg_r          <= cfgNxt;
			nextSignalDetect_r <= sigNxt;
		end
	end

	// ****************************************************************
	// Checks
	// ****************************************************************
	manual_mute_a:
	assert property (@(posedge mclk) disable iff (rst)
		(idleReg_r[`RLC_IDLE_MANUAL] && idleReg_r[`RLC_IDLE_SEL])
		|=> outputMute_r)
		else $error("manual idle did not mute");

	auto_mute_a:
	assert property (@(posedge mclk) disable iff (rst)
		!idleReg_r[`RLC_IDLE_MANUAL] |=> outputMute_r == $past(autoIdleS))
		else $error("automatic idle not followed");

	fixed_term_a:
	assert property (@(posedge mclk) disable iff (rst)
		detMode == `RLC_FAR_RECEIVER_DETECT_MODE_FIFTY |=> termination_r == rlc_pkg::RLC_TERM_FIFTY)
		else $error("fixed termination not applied");

	hiz_term_a:
	assert property (@(posedge mclk) disable iff (rst)
		(detMode != `RLC_FAR_RECEIVER_DETECT_MODE_FIFTY && !found)
		|=> termination_r == rlc_pkg::RLC_TERM_HIZ)
		else $error("termination on before detection");

	eq_write_a:
	assert property (@(posedge mclk) disable iff (rst)
		(wrEq && !eeEq) |=> ##1 laneCfg_r.equalizerLevel == $past(regWrData, 2))
		else $error("equalizer write not applied");

	status_read_a:
	assert property (@(posedge mclk) disable iff (rst)
		(regRdEn && regAddr == `RLC_ADDR_DEEMPH)
		|=> regRdData_r[7] == $past(found))
		else $error("receiver status misreported");

	gen_select_a:
	assert property (@(posedge mclk) disable iff (rst)
		1'b1 |=> laneCfg_r.earlyGenSelect == $past(swingReg_r[`RLC_SWING_GEN]))
		else $error("rate override not applied");

	force_off_a:
	assert property (@(posedge mclk) disable iff (rst)
		forceReg_r[`RLC_FORCE_OFF] |=> !nextSignalDetect_r)
		else $error("force off not applied");

	force_on_a:
	assert property (@(posedge mclk) disable iff (rst)
		(forceReg_r[`RLC_FORCE_ON] && !forceReg_r[`RLC_FORCE_OFF])
		|=> nextSignalDetect_r)
		else $error("force on not applied");

	swing_map_a:
	assert property (@(posedge mclk) disable iff (rst)
		(wrSwing && !eeSwing)
		|=> ##1 laneCfg_r.outputSwing == $past(regWrData[2:0], 2))
		else $error("swing write not applied");

endmodule : rlc_lane_regs

// ### rlc_host_model.sv
`include "rlc_cfg.svh"

module rlc_host_model (
	input  wire logic       mclk,
	output logic      [7:0] regAddr,
	output logic      [7:0] regWrData,
	output logic            regWrEn,
	output logic            regRdEn,
	input  wire logic [7:0] regRdData_r
);
	timeunit 1ns;
	timeprecision 1ns;

	// ************************************************************
	// Register bus master
	// ************************************************************
	initial begin
		regAddr   = 8'h00;
		regWrData = 8'h00;
		regWrEn   = 1'b0;
		regRdEn   = 1'b0;
	end

	task automatic wr(input logic [7:0] addr, input logic [7:0] data);
		logic [7:0] clean;
		case (addr)
			`RLC_ADDR_IDLE:   clean = data & 8'h3C;
			`RLC_ADDR_DEEMPH: clean = data & 8'h07;
			`RLC_ADDR_THRESH: clean = data & 8'h0F;
			`RLC_ADDR_RSVD:   clean = 8'h00;
			`RLC_ADDR_FORCE:  clean = data & 8'h06;
			default:          clean = data;
		endcase
		if (addr == `RLC_ADDR_SWING) clean[5:3] = 3'h5;
		@(posedge mclk);
		regAddr   <= addr;
		regWrData <= clean;
		regWrEn   <= 1'b1;
		@(posedge mclk);
		regWrEn   <= 1'b0;
		// Stale data would hide a design that samples late.
		regWrData <= ~clean;
	endtask : wr

	task automatic rd(input logic [7:0] addr, output logic [7:0] data);
		@(posedge mclk);
		regAddr <= addr;
		regRdEn <= 1'b1;
		@(posedge mclk);
		regRdEn <= 1'b0;
		#1;
		data = regRdData_r;
	endtask : rd

endmodule : rlc_host_model

// ### tb_repeater_lane_config_regs.sv
module tb_repeater_lane_config_regs;
	timeunit 1ns;
	timeprecision 1ns;

	localparam int TestCyc = 40;

	logic                      mclk;
	logic                      rst;
	logic [7:0]                regAddr;
	logic [7:0]                regWrData;
	logic                      regWrEn;
	logic                      regRdEn;
	logic [7:0]                regRdData_r;
	logic [7:0]                eeAddr;
	logic [7:0]                eeData;
	logic                      eeLoadEn;
	logic                      autoIdlePin;
	logic                      farReceiverPin;
	logic                      rateAutoPin;
	logic [1:0]                detectedRatePin;
	logic                      nextSignalPin;
	logic                      outputMute_r;
	rlc_pkg::rlc_term_type     termination_r;
	logic                      receiverProbe_r;
	rlc_pkg::rlc_lane_cfg_type laneCfg_r;
	logic                      nextSignalDetect_r;
	int                        numErrors = 0;
	int                        cmpCount = 0;
	int                        probeCount = 0;
	logic                      probePrev = 1'b0;
	logic [7:0]                rstVals [0:6] = '{8'h00, 8'h2F, 8'hAD,
		8'h02, 8'h00, 8'h00, 8'h00};
	logic [31:0]               pinCases [0:8] = '{32'h39300001,
		32'h39200100, 32'h39000101, 32'h39000000, 32'h3F040100,
		32'h3F020001, 32'h3F060000, 32'h3F000101, 32'h3F000000};

	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	rlc_host_model i_host (
		.mclk        (mclk),
		.regAddr     (regAddr),
		.regWrData   (regWrData),
		.regWrEn     (regWrEn),
		.regRdEn     (regRdEn),
		.regRdData_r (regRdData_r)
	);

	rlc_lane_regs #(.TEST_CYC(TestCyc)) i_dut (
		.mclk               (mclk),
		.rst                (rst),
		.regAddr            (regAddr),
		.regWrData          (regWrData),
		.regWrEn            (regWrEn),
		.regRdEn            (regRdEn),
		.regRdData_r        (regRdData_r),
		.eeAddr             (eeAddr),
		.eeData             (eeData),
		.eeLoadEn           (eeLoadEn),
		.autoIdlePin        (autoIdlePin),
		.farReceiverPin     (farReceiverPin),
		.rateAutoPin        (rateAutoPin),
		.detectedRatePin    (detectedRatePin),
		.nextSignalPin      (nextSignalPin),
		.outputMute_r       (outputMute_r),
		.termination_r      (termination_r),
		.receiverProbe_r    (receiverProbe_r),
		.laneCfg_r          (laneCfg_r),
		.nextSignalDetect_r (nextSignalDetect_r)
	);

	always @(posedge mclk) begin
		if (receiverProbe_r === 1'b1 && probePrev === 1'b0) probeCount++;
		probePrev <= receiverProbe_r;
	end

	// ************************************************************
	// Helpers
	// ************************************************************
	task automatic chk(input logic [7:0] got, input logic [7:0] exp,
		input string what);
		cmpCount++;
		if (got !== exp) begin
			numErrors++;
			$display("wrong value at %0t: %s got %h expected %h",
				$time, what, got, exp);
		end
	endtask : chk

	task automatic rdChk(input logic [7:0] addr, input logic [7:0] exp);
		logic [7:0] d;
		i_host.rd(addr, d);
		chk(d, exp, "read data");
	endtask : rdChk

	// Covers the two sync stages plus the output register.
	task automatic settle;
		repeat (5) @(posedge mclk);
		#1;
	endtask : settle

	task automatic testDone;
		$display("compares %0d, mismatches %0d", cmpCount, numErrors);
		if (numErrors == 0 && cmpCount > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : testDone

	initial begin
		repeat (20000) @(posedge mclk);
		numErrors++;
		$display("wrong value at %0t: watchdog expired", $time);
		testDone();
	end

	// ************************************************************
	// Tests
	// ************************************************************
	initial begin
		logic [31:0] c;
		logic        got;
		int          base;
		rst = 1'b1;
		eeAddr = 8'h00;
		eeData = 8'h00;
		eeLoadEn = 1'b0;
		autoIdlePin = 1'b0;
		farReceiverPin = 1'b0;
		rateAutoPin = 1'b0;
		detectedRatePin = 2'h0;
		nextSignalPin = 1'b0;
		repeat (10) @(posedge mclk);
		rst <= 1'b0;
		for (int i = 0; i < 7; i++) begin
			rdChk(8'h39 + 8'(i), rstVals[i]);
		end
		rdChk(8'h40, 8'h00);
		chk(laneCfg_r.equalizerLevel, 8'h2F, "eq reset");
		$display("test reset values done");

		i_host.wr(8'h3A, 8'h55);
		settle();
		chk(laneCfg_r.equalizerLevel, 8'h55, "eq");
		i_host.wr(8'h3B, 8'h40);
		settle();
		chk({7'h0, laneCfg_r.scpEnable}, 8'h00, "scp");
		chk({7'h0, laneCfg_r.earlyGenSelect}, 8'h01, "gen");
		chk({5'h0, laneCfg_r.outputSwing}, 8'h00, "swing");
		rdChk(8'h3B, 8'h68);
		i_host.wr(8'h3B, 8'h87);
		settle();
		chk({7'h0, laneCfg_r.scpEnable}, 8'h01, "scp");
		chk({5'h0, laneCfg_r.outputSwing}, 8'h07, "swing");
		for (int k = 0; k < 8; k++) begin
			i_host.wr(8'h3C, 8'(k));
			settle();
			chk({5'h0, laneCfg_r.deemphasisLevel}, 8'(k), "deemph");
		end
		rdChk(8'h3C, 8'h07);
		i_host.wr(8'h3D, 8'h0E);
		settle();
		chk({6'h0, laneCfg_r.assertThreshold}, 8'h03, "assert");
		chk({6'h0, laneCfg_r.deassertThreshold}, 8'h02, "deassert");
		$display("test fields done");

		for (int i = 0; i < 9; i++) begin
			c = pinCases[i];
			@(posedge mclk);
			if (c[31:24] == 8'h39) autoIdlePin <= c[8];
			else nextSignalPin <= c[8];
			i_host.wr(c[31:24], c[23:16]);
			settle();
			got = (c[31:24] == 8'h39) ? outputMute_r : nextSignalDetect_r;
			chk({7'h0, got}, c[7:0], "pin case");
		end
		$display("test mute and force done");

		i_host.wr(8'h39, 8'h0C);
		settle();
		chk({7'h0, termination_r}, 8'h01, "term fixed");
		i_host.wr(8'h39, 8'h00);
		settle();
		chk({7'h0, termination_r}, 8'h00, "term hiz");
		@(posedge mclk);
		farReceiverPin <= 1'b1;
		i_host.wr(8'h39, 8'h08);
		settle();
		chk({7'h0, termination_r}, 8'h00, "term before");
		repeat (TestCyc + 10) @(posedge mclk);
		#1;
		chk({7'h0, termination_r}, 8'h01, "term after");
		rdChk(8'h3C, 8'h87);
		@(posedge mclk);
		rateAutoPin <= 1'b1;
		detectedRatePin <= 2'h3;
		settle();
		rdChk(8'h3C, 8'hE7);
		@(posedge mclk);
		farReceiverPin <= 1'b0;
		rateAutoPin <= 1'b0;
		i_host.wr(8'h39, 8'h04);
		base = probeCount;
		repeat (55 * TestCyc) @(posedge mclk);
		#1;
		chk(8'(probeCount - base), 8'h32, "probe limit");
		chk({7'h0, termination_r}, 8'h00, "term none");
		rdChk(8'h3C, 8'h07);
		i_host.wr(8'h39, 8'h08);
		base = probeCount;
		repeat (55 * TestCyc) @(posedge mclk);
		#1;
		chk({7'h0, probeCount - base > 50}, 8'h01, "probe repeat");
		$display("test receiver detect done");

		@(posedge mclk);
		eeAddr <= 8'h3A;
		eeData <= 8'h11;
		eeLoadEn <= 1'b1;
		@(posedge mclk);
		eeAddr <= 8'h3F;
		eeData <= 8'h06;
		@(posedge mclk);
		eeLoadEn <= 1'b0;
		settle();
		chk(laneCfg_r.equalizerLevel, 8'h11, "ee eq");
		rdChk(8'h3F, 8'h00);
		$display("test eeprom load done");
		testDone();
	end

endmodule : tb_repeater_lane_config_regs
